// [dv/spw_supply.sv]
// Partner model: supply switch holding the power state
`timescale 1ns/100ps
module spw_supply
  import spw_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Requests from the block and the button
  input  wire logic power_on_out_n,
  input  wire logic power_off_allow,
  input  wire logic off_btn,
  // Supply state
  output logic      powered_ff,
  output int        wakes_ff
);
  // Request is only a pulse, so the supply holds the state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powered_ff <= 1'b0;
      wakes_ff   <= 0;
    end else if (!power_on_out_n) begin
      powered_ff <= 1'b1;
      wakes_ff   <= wakes_ff + 1;
    end else if (off_btn && power_off_allow) begin
      powered_ff <= 1'b0;
    end
  end
endmodule : spw_supply

// [dv/testbench.sv]
// Testbench: random enables, every wake source fired, status and readback
`timescale 1ns/100ps
module testbench import spw_pkg::*;;
  logic        clk = 0, sys_rst = 1, gia = 0, gib = 0, alarm = 0, cir = 0, btn = 0;
  logic [7:0]  pv = 8'hFF, rd_data, got, e1, e2;
  logic [31:0] seed = 32'hBE3FB9C4, rnd;
  logic [15:0] en_all;
  spw_bus_s    bus = '0;
  logic        pwr_n, off_allow, powered;
  int          wakes, w, fails = 0, samples_checked = 0, cyc = 0;
  // Pin bit per source, -1 for internal sources
  localparam int PINB[12] = '{0, 1, 2, 3, -1, -1, 4, -1, 5, 6, 7, -1};
  localparam int ENB[12]  = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 11, 13};

  always #5 clk = ~clk;

  spw_wake dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus), .rd_data(rd_data),
    .wake_pins(pv), .group_irq_a(gia), .group_irq_b(gib), .clock_alarm(alarm),
    .consumer_ir_wake(cir), .power_on_out_n(pwr_n), .power_off_allow(off_allow));
  spw_supply sup (.clk(clk), .sys_rst(sys_rst), .power_on_out_n(pwr_n),
    .power_off_allow(off_allow), .off_btn(btn), .powered_ff(powered), .wakes_ff(wakes));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 got = rd_data;
  endtask : rd

  task automatic fire(input int k);
    @(posedge clk);
    if (PINB[k] >= 0) pv[PINB[k]] <= 1'b0;
    else if (k == 4) gia <= 1'b1;
    else if (k == 5) gib <= 1'b1;
    else if (k == 7) alarm <= 1'b1;
    else cir <= 1'b1;
    @(posedge clk) {gia, gib, cir} <= 3'b000;
    // Rising pins and falling alarm must not count as events
    repeat (3) @(posedge clk);
    pv    <= 8'hFF;
    alarm <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
  endtask : fire

  task automatic push_btn();
    @(posedge clk) btn <= 1'b1;
    @(posedge clk) btn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : push_btn

  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // Hang guard, well above the roughly one thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(SPW_OFS_EN_ONE);
    check(got, 8'h00);
    rd(SPW_OFS_EN_TWO);
    check(got, 8'h80);
    check(off_allow, 1'b1);
    wr(SPW_OFS_EN_TWO, 8'hFF);
    rd(SPW_OFS_EN_TWO);
    check(got, 8'hAB);
    rd(8'hC0);
    check(got, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 5; r++) begin
      rnd    = xs();
      e1     = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : rnd[7:0];
      rnd    = xs();
      e2     = ((r == 0) ? 8'hFF : (r == 1) ? 8'h00 : rnd[7:0]) & 8'hAB;
      en_all = {e2, e1};
      wr(SPW_OFS_EN_ONE, e1);
      wr(SPW_OFS_EN_TWO, e2);
      for (int k = 0; k < 12; k++) begin
        w = wakes;
        fire(k);
        check(wakes - w, en_all[ENB[k]]);
      end
      rd(SPW_OFS_STAT);
      check(got, e1 & 8'hCF);
      rd(SPW_OFS_STAT);
      check(got, 8'h00);
      rd(SPW_OFS_STAT2);
      check(got, e2 & 8'h2B);
      rd(SPW_OFS_STAT2);
      check(got, 8'h00);
      $display("test round %0d done", r);
    end
    wr(SPW_OFS_EN_TWO, 8'h00);
    push_btn();
    check(powered, 1'b1);
    wr(SPW_OFS_EN_TWO, 8'h80);
    push_btn();
    check(powered, 1'b0);
    $display("test power off done");
    wr(SPW_OFS_EN_ONE, 8'h10);
    @(posedge clk) gia <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check(pwr_n, 1'b0);
    rd(SPW_OFS_STAT);
    check(got, 8'h10);
    @(posedge clk) gia <= 1'b0;
    repeat (3) @(posedge clk);
    rd(SPW_OFS_STAT);
    check(got, 8'h00);
    $display("test group irq done");
    results();
  end
endmodule : testbench

// [logic/spw_fall_det.sv]
// Falling-edge detector with three-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
module spw_fall_det
  import spw_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Pins and edge pulses
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] fall_pulse
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] fall;
  } spw_fd_state_s;

  spw_fd_state_s st_ff;
  spw_fd_state_s nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.s1     = pin_in;
    nxt_st.s2     = st_ff.s1;
    nxt_st.s3     = st_ff.s2;
    // A change counts once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.stable[i] = st_ff.s3[i];
      end
    end
    nxt_st.fall   = st_ff.stable & ~nxt_st.stable;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Idle-high pins: start stable high so reset release makes no edge
      st_ff <= '{s1: '1, s2: '1, s3: '1, stable: '1, fall: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fall_pulse = st_ff.fall;

endmodule : spw_fall_det

// [logic/spw_pkg.sv]
// Package: register map, field positions and carriers for the soft power wake block
package spw_pkg;

  // Register offsets (8-bit index space)
  localparam logic [7:0] SPW_OFS_EN_ONE  = 8'hB0;
  localparam logic [7:0] SPW_OFS_EN_TWO  = 8'hB1;
  localparam logic [7:0] SPW_OFS_STAT    = 8'hB2;
  localparam logic [7:0] SPW_OFS_STAT2   = 8'hB3;

  // Reset values
  localparam logic [7:0] SPW_RST_EN_ONE  = 8'h00;
  localparam logic [7:0] SPW_RST_EN_TWO  = 8'h80;
  localparam logic [7:0] SPW_RST_STAT    = 8'h00;

  // First enable register fields
  localparam int SPW_B_RING_A    = 0;
  localparam int SPW_B_RING_B    = 1;
  localparam int SPW_B_KBD_CLK   = 2;
  localparam int SPW_B_MOUSE_CLK = 3;
  localparam int SPW_B_GIRQ_A    = 4;
  localparam int SPW_B_GIRQ_B    = 5;
  localparam int SPW_B_IR_RX     = 6;
  localparam int SPW_B_ALARM     = 7;

  // Second enable register fields
  localparam int SPW_B_RX_A      = 0;
  localparam int SPW_B_RX_B      = 1;
  localparam int SPW_B_RING_PIN  = 3;
  localparam int SPW_B_CIR       = 5;
  localparam int SPW_B_OFF_EN    = 7;

  // Writable bits of the second enable register; reserved bits stay zero
  localparam logic [7:0] SPW_EN_TWO_MASK = 8'hAB;

  // Number of pin sources through the edge detector
  localparam int SPW_NUM_PINS = 8;

  // Pin bundle; all pins idle high
  typedef struct packed {
    logic ring_in_n;
    logic rx_line_b;
    logic rx_line_a;
    logic infrared_rx_pin;
    logic mouse_clock;
    logic kbd_clock;
    logic ring_b_n;
    logic ring_a_n;
  } spw_pins_s;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spw_bus_s;

endpackage : spw_pkg

// [logic/spw_wake.sv]
// Soft power wake enable, status latch and power-on request
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE_01: An enable bit at one lets its source request power on, at zero it blocks it.
// RULE_02: First enable bits 0..3 gate ring A, ring B, keyboard clock and mouse clock.
// RULE_03: First enable bits 4..7 gate group irq A, group irq B, infrared rx and clock alarm.
// RULE_04: Second enable bits 0 and 1 gate the receive lines of UART A and UART B.
// RULE_05: Second enable bit 3 lets the dedicated active-low ring pin request power on.
// RULE_06: Second enable bit 5 lets the consumer infrared wake event request power on.
// RULE_07: Second enable bit 7 resets to one and allows the power button to switch power off.
// RULE_08: A status bit per enabled source shows one when its event caused a wake.
// RULE_09: Pin sources latch a falling edge and clear when the status register is read.
// RULE_10: Group irq status bits are live and clear only at their source.
// RULE_11: Power on is the OR of each event AND its enable; reserved bits read zero.
module spw_wake
  import spw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire spw_bus_s   bus_req,
  output logic [7:0]      rd_data,
  // Wake sources
  input  wire spw_pins_s  wake_pins,
  input  wire logic       group_irq_a,
  input  wire logic       group_irq_b,
  input  wire logic       clock_alarm,
  input  wire logic       consumer_ir_wake,
  // Power control
  output logic            power_on_out_n,
  output logic            power_off_allow
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] en_one;
    logic [7:0] en_two;
    logic [7:0] stat_one;
    logic [7:0] stat_two;
    logic [7:0] rdata;
    logic       pwr_on_n;
    logic       off_allow;
  } spw_state_s;

  spw_state_s st_ff;
  spw_state_s nxt_st;

  logic [SPW_NUM_PINS-1:0] fall;
  logic                    alarm_q_ff;
  logic [7:0]              ev_one;
  logic [7:0]              ev_two;
  logic [7:0]              live_one;
  logic                    wake_req;
  logic [7:0]              stat_two_q;

  spw_fall_det #(
    .WIDTH      (SPW_NUM_PINS)
  ) u_fall (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .pin_in     (wake_pins),
    .fall_pulse (fall)
  );

  // Alarm is an internal level on this clock; take its rising edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarm_q_ff <= 1'b0;
    end else begin
      alarm_q_ff <= clock_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and wake request

  always_comb begin
    ev_one                  = 8'h00;
    ev_one[SPW_B_RING_A]    = fall[0];                          // RULE_02
    ev_one[SPW_B_RING_B]    = fall[1];                          // RULE_02
    ev_one[SPW_B_KBD_CLK]   = fall[2];                          // RULE_02
    ev_one[SPW_B_MOUSE_CLK] = fall[3];                          // RULE_02
    ev_one[SPW_B_IR_RX]     = fall[4];                          // RULE_03
    ev_one[SPW_B_ALARM]     = clock_alarm & ~alarm_q_ff;        // RULE_03
    ev_two                  = 8'h00;
    ev_two[SPW_B_RX_A]      = fall[5];                          // RULE_04
    ev_two[SPW_B_RX_B]      = fall[6];                          // RULE_04
    ev_two[SPW_B_RING_PIN]  = fall[7];                          // RULE_05
    ev_two[SPW_B_CIR]       = consumer_ir_wake;                 // RULE_06
    live_one                = 8'h00;
    live_one[SPW_B_GIRQ_A]  = group_irq_a;                      // RULE_10
    live_one[SPW_B_GIRQ_B]  = group_irq_b;                      // RULE_10
  end

  // OFF_EN is not a wake source, so masked out of the request
  assign wake_req = |((ev_one | live_one) & st_ff.en_one)                      // RULE_11
                  | |(ev_two & st_ff.en_two & SPW_EN_TWO_MASK
                      & ~(8'h01 << SPW_B_OFF_EN));                             // RULE_01

  ////////////////////////////////////////////////////////////////////////////
  // Register file and status

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        SPW_OFS_EN_ONE: nxt_st.rdata = st_ff.en_one;
        SPW_OFS_EN_TWO: nxt_st.rdata = st_ff.en_two;
        SPW_OFS_STAT:   nxt_st.rdata = st_ff.stat_one | (live_one & st_ff.en_one); // RULE_10
        SPW_OFS_STAT2:  nxt_st.rdata = st_ff.stat_two;
        default:        nxt_st.rdata = 8'h00;
      endcase
      // Read clears latched bits; a same-cycle event still sets below
      if (bus_req.addr == SPW_OFS_STAT) begin
        nxt_st.stat_one = 8'h00;                                               // RULE_09
      end
      if (bus_req.addr == SPW_OFS_STAT2) begin
        nxt_st.stat_two = 8'h00;                                               // RULE_09
      end
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        SPW_OFS_EN_ONE: nxt_st.en_one = bus_req.wdata;                         // RULE_02
        SPW_OFS_EN_TWO: nxt_st.en_two = bus_req.wdata & SPW_EN_TWO_MASK;       // RULE_11
        default:        ;
      endcase
    end
    // Only enabled sources are recorded; set wins over clear
    nxt_st.stat_one  = nxt_st.stat_one | (ev_one & st_ff.en_one);              // RULE_08
    nxt_st.stat_two  = nxt_st.stat_two | (ev_two & st_ff.en_two & SPW_EN_TWO_MASK
                                          & ~(8'h01 << SPW_B_OFF_EN));         // RULE_08
    nxt_st.pwr_on_n  = ~wake_req;                                              // RULE_01
    nxt_st.off_allow = st_ff.en_two[SPW_B_OFF_EN];                             // RULE_07
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{en_one: SPW_RST_EN_ONE, en_two: SPW_RST_EN_TWO,
                 stat_one: SPW_RST_STAT, stat_two: SPW_RST_STAT,
                 rdata: 8'h00, pwr_on_n: 1'b1, off_allow: 1'b1};               // RULE_07
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data         = st_ff.rdata;
  assign power_on_out_n  = st_ff.pwr_on_n;
  assign power_off_allow = st_ff.off_allow;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_ring_a_wake;
    @(posedge clk) disable iff (sys_rst)
      (fall[0] && st_ff.en_one[SPW_B_RING_A]) |=> !power_on_out_n;
  endproperty
  a_ring_a_wake: assert property (p_ring_a_wake) else $error("ring A did not wake"); // RULE_02

  property p_blocked;
    @(posedge clk) disable iff (sys_rst)
      (st_ff.en_one == 8'h00 && (st_ff.en_two & 8'h7F) == 8'h00) |=> power_on_out_n;
  endproperty
  a_blocked: assert property (p_blocked) else $error("wake with no enable"); // RULE_01

  property p_alarm_wake;
    @(posedge clk) disable iff (sys_rst)
      (clock_alarm && !alarm_q_ff && st_ff.en_one[SPW_B_ALARM]) |=> !power_on_out_n;
  endproperty
  a_alarm_wake: assert property (p_alarm_wake) else $error("alarm did not wake"); // RULE_03

  property p_rx_b_wake;
    @(posedge clk) disable iff (sys_rst)
      (fall[6] && st_ff.en_two[SPW_B_RX_B]) |=> !power_on_out_n;
  endproperty
  a_rx_b_wake: assert property (p_rx_b_wake) else $error("rx B did not wake"); // RULE_04

  property p_ring_pin;
    @(posedge clk) disable iff (sys_rst)
      (fall[7] && st_ff.en_two[SPW_B_RING_PIN]) |=> stat_two_q[SPW_B_RING_PIN];
  endproperty
  a_ring_pin: assert property (p_ring_pin) else $error("ring pin not recorded"); // RULE_05

  assign stat_two_q = st_ff.stat_two;

  property p_cir;
    @(posedge clk) disable iff (sys_rst)
      (consumer_ir_wake && !st_ff.en_two[SPW_B_CIR] && st_ff.en_one == 8'h00
       && (st_ff.en_two & 8'h7F) == 8'h00) |=> power_on_out_n;
  endproperty
  a_cir: assert property (p_cir) else $error("disabled ir woke"); // RULE_06

  property p_off_en;
    @(posedge clk) disable iff (sys_rst)
      ##1 power_off_allow == $past(st_ff.en_two[SPW_B_OFF_EN]);
  endproperty
  a_off_en: assert property (p_off_en) else $error("off allow mismatch"); // RULE_07

  property p_read_clear;
    @(posedge clk) disable iff (sys_rst)
      (bus_req.rd && bus_req.addr == SPW_OFS_STAT && ev_one == 8'h00)
        |=> st_ff.stat_one == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared"); // RULE_09

  property p_kbd_latch;
    @(posedge clk) disable iff (sys_rst)
      (fall[2] && st_ff.en_one[SPW_B_KBD_CLK]) |=> st_ff.stat_one[SPW_B_KBD_CLK];
  endproperty
  a_kbd_latch: assert property (p_kbd_latch) else $error("kbd edge lost"); // RULE_08

  property p_girq_live;
    @(posedge clk) disable iff (sys_rst)
      st_ff.stat_one[SPW_B_GIRQ_A] == 1'b0;
  endproperty
  a_girq_live: assert property (p_girq_live) else $error("group irq latched"); // RULE_10

  // Live group irq must show through a status read while enabled
  property p_girq_read;
    @(posedge clk) disable iff (sys_rst)
      (bus_req.rd && bus_req.addr == SPW_OFS_STAT)
        |=> rd_data[SPW_B_GIRQ_A] == $past(group_irq_a && st_ff.en_one[SPW_B_GIRQ_A]);
  endproperty
  a_girq_read: assert property (p_girq_read) else $error("group irq status wrong"); // RULE_10

  property p_reserved;
    @(posedge clk) disable iff (sys_rst)
      (st_ff.en_two & ~SPW_EN_TWO_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // RULE_11

endmodule : spw_wake
